// [design/cpu_reg_space_bitops.v]
// Purpose: Control-space register select, core register storage and added bit-manipulation operations.
// Assumes: Pipeline and debug module sit on the same clock and hold one request per cycle.
// Notes: An operation request takes the cycle; a select request in that cycle is not answered.
//
// Behaviour
// RULE1: Code 0x002 selects the cache configuration, 0x004 and 0x005 the two region attribute registers.
// RULE2: The control-move instruction writes only cache, region, vector base, PC and the two window bases.
// RULE3: Codes 0x080-0x087 load and 0x180-0x187 store the eight data registers.
// RULE4: Codes 0x088-0x08F load and 0x188-0x18F store the address registers, register 7 being a stack pointer.
// RULE5: Codes 0x800, 0x801, 0x80E and 0x80F select alternate stack pointer, vector base, status word and PC.
// RULE6: Codes 0x804 and 0x805 select the multiply-accumulate status and address mask registers.
// RULE7: Accumulators sit at 0x806, 0x809, 0x80A, 0x80B and their extension pairs at 0x807 and 0x808.
// RULE8: Codes 0xC04 and 0xC05 select the flash and sram window bases, both control-move writable.
// RULE9: Bit reverse mirrors the data register bit for bit.
// RULE10: Byte reverse swaps the byte order of the data register.
// RULE11: Find-first-one loads the distance from bit 31 to the first set bit.
// RULE12: Status push-and-load pushes the status word and then loads it with the immediate.
// RULE13: Find-first-one on an all-zero register returns 32.
// RULE14: The supervisor flag picks which of two stack pointers is register 7 and which is the alternate.
// RULE15: The low 20 bits of the vector base are held at zero.
// RULE16: Interrupt sampling is inhibited during the first instruction of an exception handler.
`timescale 1ns/1ps
`include "cpu_reg_space_regs.vh"

module cpu_reg_space_bitops (
	input  wire        i_clk_sys,      // Core clock, 40 MHz.
	input  wire        i_rst,          // Synchronous reset, active high.
	input  wire        i_rc_valid,     // Register select request.
	input  wire [11:0] i_rc_sel,       // Control register select code.
	input  wire        i_rc_write,     // High to write, low to read.
	input  wire        i_rc_control_move_instr,     // Request comes from the control-move instruction.
	input  wire [31:0] i_rc_wdata,     // Write data.
	output reg  [31:0] o_rc_rdata,     // Read data, valid with ack.
	output reg         o_rc_ack,       // Request answered, one cycle.
	output reg         o_rc_err,       // Request refused, one cycle.
	input  wire        i_op_valid,     // Bit operation request.
	input  wire [1:0]  i_op_code,      // Operation select.
	input  wire [2:0]  i_op_dreg,      // Destination data register.
	input  wire [15:0] i_op_imm,       // Immediate for status push-and-load.
	output reg         o_op_done,      // Operation completed, one cycle.
	output reg  [31:0] o_op_result,    // Result written back.
	output reg         o_push_valid,   // Stack push request, one cycle.
	output reg  [31:0] o_push_addr,    // Push address.
	output reg  [31:0] o_push_data,    // Pushed status word.
	input  wire        i_handler_first, // First handler instruction executing.
	output reg         o_irq_sample_en, // Interrupt sampling allowed.
	output reg  [2:0]  o_int_mask,     // Current interrupt level mask.
	output reg         o_supervisor    // Supervisor flag.
);

	localparam K_CACHE = 4'd0;
	localparam K_REGION_ATTR_0  = 4'd1;
	localparam K_REGION_ATTR_1  = 4'd2;
	localparam K_DREG  = 4'd3;
	localparam K_AREG  = 4'd4;
	localparam K_ALTSP = 4'd5;
	localparam K_VBR   = 4'd6;
	localparam K_MSR   = 4'd7;
	localparam K_MASK  = 4'd8;
	localparam K_ACC   = 4'd9;
	localparam K_EXT01 = 4'd10;
	localparam K_EXT23 = 4'd11;
	localparam K_PSW   = 4'd12;
	localparam K_PC    = 4'd13;
	localparam K_FLASH = 4'd14;
	localparam K_SRAM  = 4'd15;

	reg [31:0] d_q [0:7];
	reg [31:0] a_q [0:6];
	reg [31:0] acc_q [0:3];
	reg [31:0] ssp_q;
	reg [31:0] usp_q;
	reg [31:0] cache_q;
	reg [31:0] region_attr_0_q;
	reg [31:0] region_attr_1_q;
	reg [31:0] vbr_q;
	reg [31:0] msr_q;
	reg [31:0] mask_q;
	reg [31:0] ext01_q;
	reg [31:0] ext23_q;
	reg [31:0] pc_q;
	reg [31:0] flash_q;
	reg [31:0] sram_q;
	reg [15:0] sr_q;

	reg        hit;
	reg        wok;
	reg [3:0]  kind;
	reg [1:0]  acc_i;
	reg [31:0] rdata;
	reg        take;

	wire [2:0]  ri     = i_rc_sel[2:0];
	wire        sup    = sr_q[`SR_S_BIT];
	wire [31:0] act_sp = sup ? ssp_q : usp_q;  // RULE14
	wire [31:0] alt_sp = sup ? usp_q : ssp_q;  // RULE14
	wire [31:0] src    = d_q[i_op_dreg];

	// Control-space decode.
	always @* begin
		hit = 1'b1;
		wok = 1'b0;
		kind = K_CACHE;
		acc_i = 2'd0;
		if (i_rc_sel == `RC_CACHE_CONFIG) begin
			kind = K_CACHE; // RULE1
			wok = 1'b1; // RULE2
		end else if (i_rc_sel == `RC_REGION_ATTR_0) begin
			kind = K_REGION_ATTR_0; // RULE1
			wok = 1'b1; // RULE2
		end else if (i_rc_sel == `RC_REGION_ATTR_1) begin
			kind = K_REGION_ATTR_1; // RULE1
			wok = 1'b1; // RULE2
		end else if ((i_rc_sel & `RC_GPR_MASK) == `RC_GPR_BASE) begin
			kind = i_rc_sel[`RC_ADDR_BIT] ? K_AREG : K_DREG; // RULE3 RULE4
		end else if (i_rc_sel == `RC_ALT_SP) begin
			kind = K_ALTSP; // RULE5
		end else if (i_rc_sel == `RC_VECTOR_BASE) begin
			kind = K_VBR; // RULE5
			wok = 1'b1; // RULE2
		end else if (i_rc_sel == `RC_MAC_STATUS) begin
			kind = K_MSR; // RULE6
		end else if (i_rc_sel == `RC_MAC_MASK) begin
			kind = K_MASK; // RULE6
		end else if (i_rc_sel == `RC_ACC_0) begin
			kind = K_ACC; // RULE7
		end else if (i_rc_sel == `RC_ACC_1) begin
			kind = K_ACC; // RULE7
			acc_i = 2'd1;
		end else if (i_rc_sel == `RC_ACC_2) begin
			kind = K_ACC; // RULE7
			acc_i = 2'd2;
		end else if (i_rc_sel == `RC_ACC_3) begin
			kind = K_ACC; // RULE7
			acc_i = 2'd3;
		end else if (i_rc_sel == `RC_EXT_LOW_PAIR) begin
			kind = K_EXT01; // RULE7
		end else if (i_rc_sel == `RC_EXT_HIGH_PAIR) begin
			kind = K_EXT23; // RULE7
		end else if (i_rc_sel == `RC_STATUS_WORD) begin
			kind = K_PSW; // RULE5
		end else if (i_rc_sel == `RC_PROG_COUNTER) begin
			kind = K_PC; // RULE5
			wok = 1'b1; // RULE2
		end else if (i_rc_sel == `RC_FLASH_WINDOW) begin
			kind = K_FLASH; // RULE8
			wok = 1'b1; // RULE8
		end else if (i_rc_sel == `RC_SRAM_WINDOW) begin
			kind = K_SRAM; // RULE8
			wok = 1'b1; // RULE8
		end else begin
			hit = 1'b0;
		end
	end

	// Read data for the decoded register.
	always @* begin
		case (kind)
			K_CACHE: rdata = cache_q;
			K_REGION_ATTR_0:  rdata = region_attr_0_q;
			K_REGION_ATTR_1:  rdata = region_attr_1_q;
			K_DREG:  rdata = d_q[ri];
			K_AREG:  rdata = (ri == 3'd7) ? act_sp : a_q[ri];
			K_ALTSP: rdata = alt_sp;
			K_VBR:   rdata = vbr_q;
			K_MSR:   rdata = msr_q;
			K_MASK:  rdata = mask_q;
			K_ACC:   rdata = acc_q[acc_i];
			K_EXT01: rdata = ext01_q;
			K_EXT23: rdata = ext23_q;
			K_PSW:   rdata = {16'h0000, sr_q};
			K_PC:    rdata = pc_q;
			K_FLASH: rdata = flash_q;
			default: rdata = sram_q;
		endcase
	end

	// A write is taken when the source may write the target; general registers need a store code.
	always @* begin
		if (i_rc_control_move_instr) begin
			take = hit & wok; // RULE2
		end else if ((kind == K_DREG) || (kind == K_AREG)) begin
			take = hit & i_rc_sel[`RC_STORE_BIT]; // RULE3 RULE4
		end else begin
			take = hit;
		end
	end

	// Bit operations.
	wire [31:0] bit_reverse_op;
	genvar g;
	generate
		for (g = 0; g < 32; g = g + 1) begin : g_mirror
			assign bit_reverse_op[g] = src[31 - g]; // RULE9
		end
	endgenerate

	wire [31:0] byte_reverse_op = {src[7:0], src[15:8], src[23:16], src[31:24]}; // RULE10

	reg [31:0] ff1;
	integer    k;
	always @* begin
		ff1 = `FF1_NONE_FOUND; // RULE13
		for (k = 0; k < 32; k = k + 1) begin
			if (src[k]) begin
				ff1 = 32'd31 - k[31:0]; // RULE11
			end
		end
	end

	wire [15:0] sr_load = i_op_imm & `SR_WRITE_MASK;
	wire [31:0] push_at = act_sp - `PUSH_STEP;

	wire op_st  = i_op_valid && (i_op_code == `OP_STATUS_PUSH);
	wire op_dx  = i_op_valid && !op_st;
	wire rc_go  = i_rc_valid && !i_op_valid;
	wire rc_wr  = rc_go && i_rc_write && take;
	wire [3:0] k_wr = rc_wr ? kind : 4'd0;

	reg [31:0] op_res;
	always @* begin
		case (i_op_code)
			`OP_BIT_REVERSE:  op_res = bit_reverse_op;
			`OP_BYTE_REVERSE: op_res = byte_reverse_op;
			`OP_FIND_FIRST_ONE: op_res = ff1;
			default:          op_res = {16'h0000, sr_load};
		endcase
	end

	integer i;
	always @(posedge i_clk_sys) begin
		if (i_rst) begin
			for (i = 0; i < 8; i = i + 1) begin
				d_q[i] <= `REG_RESET;
			end
			for (i = 0; i < 7; i = i + 1) begin
				a_q[i] <= `REG_RESET;
			end
			for (i = 0; i < 4; i = i + 1) begin
				acc_q[i] <= `REG_RESET;
			end
			ssp_q <= `REG_RESET;
			usp_q <= `REG_RESET;
			cache_q <= `REG_RESET;
			region_attr_0_q <= `REG_RESET;
			region_attr_1_q <= `REG_RESET;
			vbr_q <= `REG_RESET;
			msr_q <= `REG_RESET;
			mask_q <= `REG_RESET;
			ext01_q <= `REG_RESET;
			ext23_q <= `REG_RESET;
			pc_q <= `REG_RESET;
			flash_q <= `REG_RESET;
			sram_q <= `REG_RESET;
			sr_q <= `SR_RESET;
		end else begin
			if (op_dx) begin
				d_q[i_op_dreg] <= op_res; // RULE9 RULE10 RULE11
			end
			if (op_st) begin
				if (sup) begin
					ssp_q <= push_at; // RULE12
				end else begin
					usp_q <= push_at; // RULE12
				end
				sr_q <= sr_load; // RULE12
			end
			if (rc_wr) begin
				case (k_wr)
					K_CACHE: cache_q <= i_rc_wdata;
					K_REGION_ATTR_0:  region_attr_0_q <= i_rc_wdata;
					K_REGION_ATTR_1:  region_attr_1_q <= i_rc_wdata;
					K_DREG:  d_q[ri] <= i_rc_wdata;
					K_AREG: begin
						if (ri != 3'd7) begin
							a_q[ri] <= i_rc_wdata;
						end else if (sup) begin
							ssp_q <= i_rc_wdata; // RULE14
						end else begin
							usp_q <= i_rc_wdata; // RULE14
						end
					end
					K_ALTSP: begin
						if (sup) begin
							usp_q <= i_rc_wdata; // RULE14
						end else begin
							ssp_q <= i_rc_wdata; // RULE14
						end
					end
					K_VBR:   vbr_q <= i_rc_wdata & `VBR_KEEP_MASK; // RULE15
					K_MSR:   msr_q <= i_rc_wdata;
					K_MASK:  mask_q <= i_rc_wdata;
					K_ACC:   acc_q[acc_i] <= i_rc_wdata;
					K_EXT01: ext01_q <= i_rc_wdata;
					K_EXT23: ext23_q <= i_rc_wdata;
					K_PSW:   sr_q <= i_rc_wdata[15:0] & `SR_WRITE_MASK;
					K_PC:    pc_q <= i_rc_wdata;
					K_FLASH: flash_q <= i_rc_wdata;
					default: sram_q <= i_rc_wdata;
				endcase
			end
		end
	end

	// Answers and status outputs, all registered.
	always @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_rc_rdata <= `REG_RESET;
			o_rc_ack <= 1'b0;
			o_rc_err <= 1'b0;
			o_op_done <= 1'b0;
			o_op_result <= `REG_RESET;
			o_push_valid <= 1'b0;
			o_push_addr <= `REG_RESET;
			o_push_data <= `REG_RESET;
			o_irq_sample_en <= 1'b0;
			o_int_mask <= 3'd7;
			o_supervisor <= 1'b1;
		end else begin
			o_rc_ack <= rc_go && (i_rc_write ? take : hit);
			o_rc_err <= rc_go && (i_rc_write ? !take : !hit); // RULE2
			o_rc_rdata <= (rc_go && !i_rc_write && hit) ? rdata : `REG_RESET;
			o_op_done <= i_op_valid;
			o_op_result <= i_op_valid ? op_res : o_op_result;
			o_push_valid <= op_st; // RULE12
			o_push_addr <= op_st ? push_at : o_push_addr;
			o_push_data <= op_st ? {16'h0000, sr_q} : o_push_data; // RULE12
			o_irq_sample_en <= !i_handler_first; // RULE16
			o_int_mask <= sr_q[`SR_IMASK_HI:`SR_IMASK_LO];
			o_supervisor <= sup;
		end
	end

endmodule // cpu_reg_space_bitops

// [common/cpu_reg_space_regs.vh]
// Purpose: Control-space codes, field positions and constants of the core register block.
// Assumes: Codes are the 12-bit values carried on the register select port.
// Notes: Included by the core register block only.
`ifndef CPU_REG_SPACE_REGS_VH
`define CPU_REG_SPACE_REGS_VH

`define RC_CACHE_CONFIG   12'h002
`define RC_REGION_ATTR_0  12'h004
`define RC_REGION_ATTR_1  12'h005
`define RC_GPR_MASK       12'hEF0
`define RC_GPR_BASE       12'h080
`define RC_STORE_BIT      8
`define RC_ADDR_BIT       3
`define RC_ALT_SP         12'h800
`define RC_VECTOR_BASE    12'h801
`define RC_MAC_STATUS     12'h804
`define RC_MAC_MASK       12'h805
`define RC_ACC_0          12'h806
`define RC_EXT_LOW_PAIR   12'h807
`define RC_EXT_HIGH_PAIR  12'h808
`define RC_ACC_1          12'h809
`define RC_ACC_2          12'h80A
`define RC_ACC_3          12'h80B
`define RC_STATUS_WORD    12'h80E
`define RC_PROG_COUNTER   12'h80F
`define RC_FLASH_WINDOW   12'hC04
`define RC_SRAM_WINDOW    12'hC05

`define SR_S_BIT          13
`define SR_IMASK_HI       10
`define SR_IMASK_LO       8
`define SR_WRITE_MASK     16'hB71F
`define SR_RESET          16'h2700
`define VBR_ZERO_BITS     20
`define VBR_KEEP_MASK     32'hFFF00000
`define REG_RESET         32'h00000000

`define OP_BIT_REVERSE    2'h0
`define OP_BYTE_REVERSE   2'h1
`define OP_FIND_FIRST_ONE 2'h2
`define OP_STATUS_PUSH    2'h3
`define FF1_NONE_FOUND    32'h00000020
`define PUSH_STEP         32'h00000004

`endif

// [sim/cpu_reg_space_bitops_chk.sv]
// Purpose: Assertions on the select and bit operation ports.
// Assumes: One core clock, synchronous active-high reset.
// Notes: Bound into every instance of the block.
`timescale 1ns/1ps
module cpu_reg_space_bitops_chk (
	input wire        i_clk_sys,       // Clock.
	input wire        i_rst,           // Reset.
	input wire        i_rc_valid,      // Request.
	input wire [11:0] i_rc_sel,        // Code.
	input wire        i_rc_write,      // Write.
	input wire        i_rc_control_move_instr,      // Move.
	input wire [31:0] i_rc_wdata,      // Data.
	input wire [31:0] o_rc_rdata,      // Data.
	input wire        o_rc_ack,        // Done.
	input wire        o_rc_err,        // Refused.
	input wire        i_op_valid,      // Op.
	input wire [1:0]  i_op_code,       // Code.
	input wire [2:0]  i_op_dreg,       // Register.
	input wire [15:0] i_op_imm,        // Immediate.
	input wire        o_op_done,       // Done.
	input wire [31:0] o_op_result,     // Result.
	input wire        o_push_valid,    // Push.
	input wire [31:0] o_push_addr,     // Address.
	input wire [31:0] o_push_data,     // Data.
	input wire        i_handler_first, // Handler.
	input wire        o_irq_sample_en, // Sampling.
	input wire [2:0]  o_int_mask,      // Mask.
	input wire        o_supervisor     // Mode.
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	wire       sel_req = i_rc_valid && !i_op_valid;
	wire       mv_wr   = sel_req && i_rc_write && i_rc_control_move_instr;
	wire [2:0] imm_msk = i_op_imm[10:8];
	wire       imm_sup = i_op_imm[13];
	function automatic [31:0] mirror(input [31:0] x);
		for (int k = 0; k < 32; k++) mirror[k] = x[31-k];
	endfunction
	sequence s_rev;
		i_op_valid && i_op_code == 2'h0;
	endsequence
	sequence s_push;
		i_op_valid && i_op_code == 2'h3;
	endsequence
	AST_ANSWER: assert property (sel_req |=> o_rc_ack != o_rc_err) else $error("no single answer");
	AST_LOAD_WR: assert property (sel_req && i_rc_write && i_rc_sel[11:4] == 8'h08 |=> o_rc_err)
		else $error("load code write taken");
	AST_CONTROL_MOVE_INSTR_RO: assert property (mv_wr && i_rc_sel inside {12'h800, 12'h804, 12'h805, 12'h80E} |=> o_rc_err)
		else $error("control move wrote a fixed register");
	AST_CONTROL_MOVE_INSTR_RW: assert property (mv_wr && i_rc_sel inside {12'h801, 12'h80F, 12'hC04, 12'hC05} |=> o_rc_ack)
		else $error("control move write refused");
	AST_VBR_LOW: assert property (sel_req && !i_rc_write && i_rc_sel == 12'h801 |=> o_rc_rdata[19:0] == 20'h0)
		else $error("vector base low bits set");
	AST_OP_DONE: assert property (i_op_valid |=> o_op_done && !o_rc_ack) else $error("op not done");
	AST_REV_TWICE: assert property (s_rev ##1 (s_rev and $stable(i_op_dreg)) |=>
		o_op_result == mirror($past(o_op_result))) else $error("bit reverse wrong");
	AST_FF1_BOUND: assert property (i_op_valid && i_op_code == 2'h2 |=> o_op_result <= 32'h20)
		else $error("find first one out of range");
	AST_PUSH_LOAD: assert property (s_push |=> (o_push_valid && o_push_data[10:8] == o_int_mask &&
		o_push_data[13] == o_supervisor) ##1
		(o_int_mask == $past(imm_msk, 2) && o_supervisor == $past(imm_sup, 2))) else $error("push load wrong");
	AST_SP_STEP: assert property ((s_push and imm_sup == o_supervisor &&
		!$past(i_op_valid || (i_rc_valid && i_rc_write))) ##1 s_push |=>
		o_push_addr == $past(o_push_addr) - 32'h4) else $error("stack pointer step wrong");
	AST_IRQ_INH: assert property (i_handler_first |=> !o_irq_sample_en) else $error("sampling not inhibited");
endmodule // cpu_reg_space_bitops_chk

bind cpu_reg_space_bitops cpu_reg_space_bitops_chk chk (.*);

// [sim/cpu_pipe_model.sv]
// Purpose: Pipeline and debug side driving the select and operation ports.
// Assumes: Caller waits in the task until the answer is sampled.
// Notes: Idle fields carry the inverse of the last request.
`timescale 1ns/1ps
module cpu_pipe_model (
	input  wire        i_clk_sys,      // Clock.
	output reg         o_rc_valid,     // Request.
	output reg  [11:0] o_rc_sel,       // Code.
	output reg         o_rc_write,     // Write.
	output reg         o_rc_control_move_instr,     // Move.
	output reg  [31:0] o_rc_wdata,     // Data.
	output reg         o_op_valid,     // Op.
	output reg  [1:0]  o_op_code,      // Code.
	output reg  [2:0]  o_op_dreg,      // Register.
	output reg  [15:0] o_op_imm,       // Immediate.
	output reg         o_handler_first // Handler.
);
	integer hseed = 89676;
	initial begin
		{o_rc_valid, o_rc_sel, o_rc_write, o_rc_control_move_instr, o_rc_wdata} = 47'h0;
		{o_op_valid, o_op_code, o_op_dreg, o_op_imm, o_handler_first} = 23'h0;
	end
	always @(posedge i_clk_sys) begin
		o_handler_first <= ($random(hseed) & 32'h1) != 32'h0;
	end
	task automatic rc(input [11:0] s, input w, input m, input [31:0] d);
		@(posedge i_clk_sys);
		{o_rc_valid, o_rc_sel, o_rc_write, o_rc_control_move_instr, o_rc_wdata} <= {1'b1, s, w, m, d};
		@(posedge i_clk_sys);
		{o_rc_valid, o_rc_sel, o_rc_write, o_rc_control_move_instr, o_rc_wdata} <= {1'b0, ~s, ~w, ~m, ~d};
		#1;
	endtask
	task automatic op(input [1:0] c, input [2:0] r, input [15:0] im);
		@(posedge i_clk_sys);
		{o_op_valid, o_op_code, o_op_dreg, o_op_imm} <= {1'b1, c, r, im};
		@(posedge i_clk_sys);
		{o_op_valid, o_op_code, o_op_dreg, o_op_imm} <= {1'b0, ~c, ~r, ~im};
		#1;
	endtask
	// Two operations in consecutive cycles on one register; only the immediate changes.
	task automatic op2(input [1:0] c, input [2:0] r, input [15:0] im0, input [15:0] im1);
		@(posedge i_clk_sys);
		{o_op_valid, o_op_code, o_op_dreg, o_op_imm} <= {1'b1, c, r, im0};
		@(posedge i_clk_sys);
		o_op_imm <= im1;
		@(posedge i_clk_sys);
		{o_op_valid, o_op_code, o_op_dreg, o_op_imm} <= {1'b0, ~c, ~r, ~im1};
		#1;
	endtask
endmodule // cpu_pipe_model

// [sim/test_cpu_reg_space_bitops.sv]
// Purpose: Self-checking bench of the register select and bit operations.
// Assumes: Requests come one at a time through the pipeline model.
// Notes: Expected values come from bench functions and tracked copies.
`timescale 1ns/1ps
module test_cpu_reg_space_bitops;
	reg         i_clk_sys = 1'b0;
	reg         i_rst = 1'b1;
	wire        i_rc_valid, i_rc_write, i_rc_control_move_instr, i_op_valid, i_handler_first;
	wire [11:0] i_rc_sel;
	wire [31:0] i_rc_wdata, o_rc_rdata, o_op_result, o_push_addr, o_push_data;
	wire [1:0]  i_op_code;
	wire [2:0]  i_op_dreg, o_int_mask;
	wire [15:0] i_op_imm;
	wire        o_rc_ack, o_rc_err, o_op_done, o_push_valid, o_irq_sample_en, o_supervisor;
	integer     fail_count = 0;
	integer     n_compared = 0;
	integer     seed = 89676;
	integer     i;
	reg [31:0]  dref [0:7];
	reg [31:0]  v, e;
	reg [15:0]  sr;
	reg [12:0]  tab [0:18] = '{13'h1002, 13'h1004, 13'h1005, 13'h0180, 13'h0188, 13'h0800, 13'h1801,
		13'h0804, 13'h0805, 13'h0806, 13'h0807, 13'h0808, 13'h0809, 13'h080A, 13'h080B, 13'h080E,
		13'h180F, 13'h1C04, 13'h1C05};
	always #12.5 i_clk_sys = ~i_clk_sys;
	cpu_pipe_model pm (.i_clk_sys(i_clk_sys), .o_rc_valid(i_rc_valid), .o_rc_sel(i_rc_sel),
		.o_rc_write(i_rc_write), .o_rc_control_move_instr(i_rc_control_move_instr), .o_rc_wdata(i_rc_wdata), .o_op_valid(i_op_valid),
		.o_op_code(i_op_code), .o_op_dreg(i_op_dreg), .o_op_imm(i_op_imm), .o_handler_first(i_handler_first));
	cpu_reg_space_bitops dut (.*);
	function [31:0] exp_op(input [1:0] c, input [31:0] x);
		integer k;
		begin
			exp_op = 32'h20;
			for (k = 0; k < 32; k = k + 1) begin
				if (c == 2'h0) exp_op[k] = x[31-k];
				else if (c == 2'h2 && x[k]) exp_op = 31 - k;
			end
			if (c == 2'h1) exp_op = {x[7:0], x[15:8], x[23:16], x[31:24]};
		end
	endfunction
	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task req(input [11:0] s, input w, input m, input [31:0] d, input ok);
		begin
			pm.rc(s, w, m, d);
			chk({30'h0, o_rc_ack, o_rc_err}, ok ? 32'h2 : 32'h1);
		end
	endtask
	task rd(input [11:0] s, input [31:0] x);
		begin
			req(s, 1'b0, 1'b0, ~x, 1'b1);
			chk(o_rc_rdata, x);
		end
	endtask
	task stop_test;
		begin
			$display("Compared %0d, mismatches %0d", n_compared, fail_count);
			if (fail_count == 0 && n_compared > 0) $display("Finished cleanly");
			else $display("Finished with errors");
			$finish;
		end
	endtask
	initial begin
		#100000;
		fail_count = fail_count + 1;
		stop_test;
	end
	initial begin
		repeat (3) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		rd(12'h80E, 32'h2700);
		chk({28'h0, o_supervisor, o_int_mask}, 32'hF);
		$display("reset values done");
		for (i = 0; i < 19; i = i + 1) begin
			v = $random(seed);
			if (tab[i][11:0] == 12'h80E) v = (v & 32'hB71F) | 32'h2000;
			if (tab[i][11:0] == 12'h80E) sr = v[15:0];
			e = (tab[i][11:0] == 12'h801) ? (v & 32'hFFF00000) : v;
			req(tab[i][11:0], 1'b1, 1'b1, ~v, tab[i][12]);
			req(tab[i][11:0], 1'b1, 1'b0, v, 1'b1);
			rd(tab[i][11:0] & 12'hEFF, e);
		end
		req(12'h080, 1'b1, 1'b0, v, 1'b0);
		req(12'h7FF, 1'b0, 1'b0, v, 1'b0);
		$display("register map done");
		for (i = 0; i < 16; i = i + 1) begin
			v = (i == 0) ? 32'h0 : (i == 1) ? 32'h1 : (i == 2) ? 32'h80000000 : $random(seed);
			if (i < 8) dref[i] = v;
			req({8'h18, i[3:0]}, 1'b1, 1'b0, v, 1'b1);
			rd({8'h08, i[3:0]}, v);
		end
		$display("data and address registers done");
		pm.op(2'h2, 3'h0, 16'h0);
		chk(o_op_result, 32'h20);
		pm.op(2'h1, 3'h1, 16'h0);
		chk(o_op_result, 32'h01000000);
		pm.op(2'h2, 3'h2, 16'h0);
		chk(o_op_result, 32'h0);
		dref[0] = 32'h20;
		dref[1] = 32'h01000000;
		dref[2] = 32'h0;
		for (i = 0; i < 60; i = i + 1) begin
			v = $random(seed);
			if (v[1:0] == 2'h3) v[1:0] = 2'h0;
			e = exp_op(v[1:0], dref[v[4:2]]);
			pm.op(v[1:0], v[4:2], 16'h0);
			chk({31'h0, o_op_done}, 32'h1);
			chk(o_op_result, e);
			dref[v[4:2]] = e;
		end
		pm.op2(2'h0, 3'h3, 16'h0, 16'h0);
		chk(o_op_result, dref[3]);
		for (i = 0; i < 8; i = i + 1) rd({8'h08, 1'b0, i[2:0]}, dref[i]);
		$display("bit operations done");
		req(12'h18F, 1'b1, 1'b0, 32'h00001000, 1'b1);
		pm.op(2'h3, 3'h0, 16'h2705);
		chk({31'h0, o_push_valid}, 32'h1);
		chk(o_push_addr, 32'h00000FFC);
		chk(o_push_data, {16'h0, sr});
		rd(12'h08F, 32'h00000FFC);
		pm.op(2'h3, 3'h0, 16'h0000);
		chk(o_push_data, 32'h00002705);
		rd(12'h800, 32'h00000FF8);
		chk({28'h0, o_supervisor, o_int_mask}, 32'h0);
		req(12'h18F, 1'b1, 1'b0, 32'h00002000, 1'b1);
		pm.op2(2'h3, 3'h0, 16'h0300, 16'h0000);
		chk({31'h0, o_push_valid}, 32'h1);
		chk(o_push_addr, 32'h00001FF8);
		chk(o_push_data, 32'h00000300);
		rd(12'h08F, 32'h00001FF8);
		rd(12'h800, 32'h00000FF8);
		$display("status push done");
		for (i = 0; i < 20; i = i + 1) begin
			@(posedge i_clk_sys);
			#1;
			v[0] = i_handler_first;
			@(posedge i_clk_sys);
			#1;
			chk({31'h0, o_irq_sample_en}, {31'h0, ~v[0]});
		end
		$display("interrupt inhibit done");
		stop_test;
	end
endmodule // test_cpu_reg_space_bitops
